// *** txip_top.sv ***
`timescale 1ns/10ps
`include "txip_cfg.svh"
module txip_top
  import txip_pkg::*;
#(
  parameter int FIFO_W = 8,
  parameter int FIFO_D = 16
) (
  // Clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RESET_N,
  // Channel command
  input  wire logic              CMD_VALID,
  input  wire logic              TRANSMIT_HOLD_CMD,
  // Serial time slot marker, asynchronous
  input  wire logic              SLOT_PIN,
  // Descriptor read port to shared memory
  output logic                   DESC_RD_REQ,
  input  wire logic              DESC_RD_ACK,
  input  wire logic [31:0]       DESC_RD_DATA,
  // Frame data in
  input  wire logic              DATA_VALID,
  output logic                   DATA_READY,
  input  wire logic [FIFO_W-1:0] DATA_IN,
  // Serial character out, one per slot
  output logic                   CHAR_VALID,
  output logic                   CHAR_IDLE,
  output logic      [FIFO_W-1:0] CHAR_DATA,
  // Status
  output logic                   CHAN_HELD,
  output logic                   CHAN_PAUSED
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    txip_state_t state;
    logic [1:0]  slot_cnt;
    logic [`TXIP_FILL_W:0] fill_left;
    txip_desc_t  desc;
    logic        req;
    logic        char_valid;
    logic        char_idle;
    logic [FIFO_W-1:0] char_data;
  } txip_st_t;

  txip_st_t          st_r;
  txip_st_t          st_nxt;
  txip_cmd_t         cmd;
  txip_desc_t        rd_desc;
  logic              slot;
  logic              f_valid;
  logic              f_ready;
  logic [FIFO_W-1:0] f_data;

  assign cmd.valid = CMD_VALID;
  assign cmd.hold  = TRANSMIT_HOLD_CMD;

  function automatic txip_desc_t decode_desc(input logic [31:0] w);
    txip_desc_t d;
    d.pause = w[`TXIP_DESC_PAUSE_BIT];
    d.fill  = w[`TXIP_DESC_FILL_LSB +: `TXIP_FILL_W];
    d.len   = w[`TXIP_DESC_LEN_LSB +: `TXIP_DESC_LEN_W];
    return d;
  endfunction

  assign rd_desc = decode_desc(DESC_RD_DATA);

  // ----------------------------------------------------------------
  // Slot pacing and data buffer
  // ----------------------------------------------------------------
  txip_slot u_slot (
    .CLOCK      (CLOCK),
    .RESET_N    (RESET_N),
    .slot_pin   (SLOT_PIN),
    .slot_pulse (slot)
  );

  txip_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .CLOCK     (CLOCK),
    .RESET_N   (RESET_N),
    .in_valid  (DATA_VALID),
    .in_ready  (DATA_READY),
    .in_data   (DATA_IN),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // Drain one byte per slot while sending; an empty buffer stalls the frame
  assign f_ready = (st_r.state == TXIP_SEND) && slot;

  // ----------------------------------------------------------------
  // Control
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt            = st_r;
    st_nxt.char_valid = 1'b0;
    if (slot) begin
      st_nxt.slot_cnt = st_r.slot_cnt + 2'd1;
    end
    case (st_r.state)
      TXIP_HELD: begin
        st_nxt.req = 1'b0;
      end
      TXIP_WAIT: begin
        // Idle between polls; poll on every fourth slot
        if (slot && st_r.slot_cnt == 2'(`TXIP_POLL_SPACING - 1)) begin
          st_nxt.state = TXIP_FETCH;
          st_nxt.req   = 1'b1;
        end
      end
      TXIP_FETCH: begin
        if (DESC_RD_ACK) begin
          st_nxt.req  = 1'b0;
          st_nxt.desc = rd_desc;
          if (rd_desc.pause) begin
            st_nxt.state = TXIP_PAUSE;
          end else if (rd_desc.len != '0) begin
            st_nxt.state = TXIP_SEND;
          end else begin
            st_nxt.state = TXIP_WAIT;
          end
        end
      end
      TXIP_PAUSE: begin
        // Re-read the pause flag in every assigned slot
        if (slot) begin
          st_nxt.state = TXIP_FETCH;
          st_nxt.req   = 1'b1;
        end
      end
      TXIP_SEND: begin
        if (slot && f_valid) begin
          st_nxt.char_valid = 1'b1;
          st_nxt.char_idle  = 1'b0;
          st_nxt.char_data  = f_data;
          st_nxt.desc.len   = st_r.desc.len - 16'd1;
          if (st_r.desc.len == 16'd1) begin
            if (st_r.desc.fill != '0) begin
              st_nxt.state     = TXIP_FILL;
              st_nxt.fill_left = {1'b0, st_r.desc.fill} + 9'd1;
            end else begin
              st_nxt.state = TXIP_FETCH;
              st_nxt.req   = 1'b1;
            end
          end
        end
      end
      TXIP_FILL: begin
        // Descriptor is left alone until the last idle character
        if (slot) begin
          st_nxt.char_valid = 1'b1;
          st_nxt.char_idle  = 1'b1;
          st_nxt.char_data  = '0;
          st_nxt.fill_left  = st_r.fill_left - 9'd1;
          if (st_r.fill_left == 9'd1) begin
            st_nxt.state = TXIP_FETCH;
            st_nxt.req   = 1'b1;
          end
        end
      end
      default: begin
        st_nxt.state = TXIP_HELD;
        st_nxt.req   = 1'b0;
      end
    endcase
    // Hold command overrides the next state from any state; a release only acts in TXIP_HELD
    if (cmd.valid) begin
      if (cmd.hold) begin
        st_nxt.state = TXIP_HELD;
        st_nxt.req   = 1'b0;
      end else if (st_r.state == TXIP_HELD) begin
        st_nxt.state = TXIP_FETCH;
        st_nxt.req   = 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r       <= '0;
      st_r.state <= TXIP_HELD;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign DESC_RD_REQ = st_r.req;
  assign CHAR_VALID  = st_r.char_valid;
  assign CHAR_IDLE   = st_r.char_idle;
  assign CHAR_DATA   = st_r.char_data;
  assign CHAN_HELD   = (st_r.state == TXIP_HELD);
  assign CHAN_PAUSED = (st_r.state == TXIP_PAUSE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  sequence hold_cmd_s;
    CMD_VALID && TRANSMIT_HOLD_CMD;
  endsequence

  hold_stops_a: assert property (
    hold_cmd_s |=> CHAN_HELD && !DESC_RD_REQ)
    else $error("Hold command did not stop the channel");

  held_quiet_a: assert property (
    CHAN_HELD && !CMD_VALID |=> !DESC_RD_REQ)
    else $error("Memory access while held");

  resume_cmd_a: assert property (
    CHAN_HELD && CMD_VALID && !TRANSMIT_HOLD_CMD |=> DESC_RD_REQ)
    else $error("Release command did not fetch");

  fill_load_a: assert property (
    st_r.state == TXIP_SEND && slot && f_valid && st_r.desc.len == 16'd1
    && st_r.desc.fill != '0 && !CMD_VALID
    |=> st_r.fill_left == $past(st_r.desc.fill) + 9'd1)
    else $error("Wrong idle character count");

  fill_nopoll_a: assert property (
    st_r.state == TXIP_FILL |-> !DESC_RD_REQ)
    else $error("Descriptor polled during idle fill");

  pause_poll_a: assert property (
    CHAN_PAUSED && slot && !CMD_VALID |=> DESC_RD_REQ)
    else $error("Paused flag not re-read in slot");

  pause_resume_a: assert property (
    st_r.state == TXIP_FETCH && DESC_RD_ACK && !rd_desc.pause
    && rd_desc.len != '0 && !CMD_VALID |=> st_r.state == TXIP_SEND)
    else $error("Transmission did not resume");

  wait_spacing_a: assert property (
    st_r.state == TXIP_WAIT && slot && st_r.slot_cnt != 2'd3
    |=> !DESC_RD_REQ)
    else $error("Poll before fourth slot");

  nofill_cont_a: assert property (
    st_r.state == TXIP_SEND && slot && f_valid && st_r.desc.len == 16'd1
    && st_r.desc.fill == '0 && !CMD_VALID |=> DESC_RD_REQ)
    else $error("Zero fill did not continue at once");

  // ----------------------------------------------------------------
  // Step checks
  // ----------------------------------------------------------------
  // One slot of frame or fill output, with no command in the way
  sequence send_slot_s;
    st_r.state == TXIP_SEND && slot && f_valid && !CMD_VALID;
  endsequence

  sequence fill_slot_s;
    st_r.state == TXIP_FILL && slot && !CMD_VALID;
  endsequence

  sequence fill_last_s;
    fill_slot_s ##0 st_r.fill_left == 9'd1;
  endsequence

  sequence fill_more_s;
    fill_slot_s ##0 st_r.fill_left != 9'd1;
  endsequence

  send_char_a: assert property (
    send_slot_s |=> CHAR_VALID && !CHAR_IDLE && CHAR_DATA == $past(f_data))
    else $error("Frame byte not sent in its slot");

  fill_char_a: assert property (
    fill_slot_s |=> CHAR_VALID && CHAR_IDLE && CHAR_DATA == '0)
    else $error("Idle character missing in fill slot");

  fill_more_a: assert property (
    fill_more_s |=> st_r.state == TXIP_FILL)
    else $error("Idle fill ended early");

  fill_end_a: assert property (
    fill_last_s |=> st_r.state == TXIP_FETCH && DESC_RD_REQ)
    else $error("Poll did not follow the last idle character");

  held_noreq_a: assert property (
    CHAN_HELD |-> !DESC_RD_REQ)
    else $error("Request raised while held");

  held_nochar_a: assert property (
    CHAN_HELD |=> !CHAR_VALID)
    else $error("Character sent while held");

  req_stands_a: assert property (
    DESC_RD_REQ && !DESC_RD_ACK && !CMD_VALID |=> DESC_RD_REQ)
    else $error("Descriptor request dropped before its answer");

  pause_stay_a: assert property (
    CHAN_PAUSED && !slot && !CMD_VALID |=> CHAN_PAUSED && !DESC_RD_REQ)
    else $error("Pause left without a slot");

  wait_quiet_a: assert property (
    st_r.state == TXIP_WAIT && !slot |=> !DESC_RD_REQ)
    else $error("Poll outside a slot");
endmodule

// *** txip_cfg.svh ***
`ifndef TXIP_CFG_SVH
`define TXIP_CFG_SVH
// Normal spacing of descriptor polls, in assigned time slots
`define TXIP_POLL_SPACING     4
// Width of the interframe fill count field
`define TXIP_FILL_W           8
// Descriptor field positions in the read word
`define TXIP_DESC_PAUSE_BIT   31
`define TXIP_DESC_FILL_LSB    16
`define TXIP_DESC_LEN_LSB     0
`define TXIP_DESC_LEN_W       16
// Reset values
`define TXIP_FILL_RST         8'h00
`define TXIP_LEN_RST          16'h0000
`endif

// *** txip_pkg.sv ***
package txip_pkg;
  typedef enum logic [2:0] {
    TXIP_HELD  = 3'b000,
    TXIP_FETCH = 3'b001,
    TXIP_WAIT  = 3'b010,
    TXIP_SEND  = 3'b011,
    TXIP_FILL  = 3'b100,
    TXIP_PAUSE = 3'b101
  } txip_state_t;

  typedef struct packed {
    logic        valid;
    logic        hold;
  } txip_cmd_t;

  typedef struct packed {
    logic        pause;
    logic [7:0]  fill;
    logic [15:0] len;
  } txip_desc_t;
endpackage

// *** txip_fifo.sv ***
`timescale 1ns/10ps
module txip_fifo
  import txip_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             CLOCK,
  input  wire logic             RESET_N,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } txip_fifo_st_t;

  txip_fifo_st_t    st_r;
  txip_fifo_st_t    st_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (st_r.cnt != DEPTH[AW:0]);
  assign out_valid = (st_r.cnt != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[st_r.rp];

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Storage needs no reset; only written words are ever read
  always_ff @(posedge CLOCK) begin
    if (push) begin
      mem_r[st_r.wp] <= in_data;
    end
  end
endmodule

// *** txip_slot.sv ***
`timescale 1ns/10ps
module txip_slot
  import txip_pkg::*;
(
  // Clock and reset
  input  wire logic CLOCK,
  input  wire logic RESET_N,
  // Raw slot marker from the serial side
  input  wire logic slot_pin,
  // One pulse per assigned time slot
  output logic      slot_pulse
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } txip_slot_st_t;

  txip_slot_st_t st_r;
  txip_slot_st_t st_nxt;

  // Third stage gives an edge without touching the first synchroniser stage
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = slot_pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign slot_pulse = st_r.s2 && !st_r.s3;
endmodule

// *** txip_mem.sv ***
`timescale 1ns/10ps
module txip_mem
  import txip_pkg::*;
(
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  // Descriptor read port
  input  wire logic        rd_req,
  output logic             rd_ack,
  output logic      [31:0] rd_data,
  // Answer delay in cycles
  input  wire logic [1:0]  delay
);
  // ----------------
  // Descriptor store
  // ----------------
  // An empty store answers a zero-length frame, so polling goes on
  txip_desc_t q[$];
  txip_desc_t d;
  int         wait_cnt;

  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_ack   <= 1'b0;
      rd_data  <= 32'h0;
      wait_cnt = 0;
    end else if (rd_req && !rd_ack && wait_cnt >= delay) begin
      d = '0;
      if (q.size() > 0) begin
        d = q.pop_front();
      end
      rd_ack   <= 1'b1;
      rd_data  <= {d.pause, 7'h00, d.fill, d.len};
      wait_cnt = 0;
    end else begin
      // Stale word is inverted so a late sample never looks valid
      rd_ack   <= 1'b0;
      rd_data  <= ~rd_data;
      wait_cnt = rd_req ? wait_cnt + 1 : 0;
    end
  end
endmodule

// *** txip_top_tb_top.sv ***
`timescale 1ns/10ps
module txip_top_tb_top
  import txip_pkg::*;
;
  logic        clock = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, hold = 1'b0;
  logic        slot_pin = 1'b0, d_valid = 1'b0, rd_req, rd_ack, d_ready;
  logic        c_valid, c_idle, held, paused;
  logic [31:0] rd_data;
  logic [7:0]  d_in = 8'h00, c_data;
  logic [1:0]  delay = 2'h0;
  int          seed = 8659, error_cnt = 0, num_checks = 0, slot_no = 0;
  logic [8:0]  exp_q[$], got_q[$];
  int          rd_slot[$], rd_chars[$], ch_slot[$];

  txip_top dut (.CLOCK(clock), .RESET_N(reset_n), .CMD_VALID(cmd_valid),
    .TRANSMIT_HOLD_CMD(hold), .SLOT_PIN(slot_pin), .DESC_RD_REQ(rd_req),
    .DESC_RD_ACK(rd_ack), .DESC_RD_DATA(rd_data), .DATA_VALID(d_valid),
    .DATA_READY(d_ready), .DATA_IN(d_in), .CHAR_VALID(c_valid),
    .CHAR_IDLE(c_idle), .CHAR_DATA(c_data), .CHAN_HELD(held),
    .CHAN_PAUSED(paused));
  txip_mem mem (.CLOCK(clock), .RESET_N(reset_n), .rd_req(rd_req),
    .rd_ack(rd_ack), .rd_data(rd_data), .delay(delay));

  // ----------------------
  // Clock, slots, monitor
  // ----------------------
  always #10 clock = ~clock;
  // Slots are ten cycles apart so a slow answer still lands in its slot
  always begin
    repeat (7) @(negedge clock);
    slot_pin = 1'b1;
    slot_no++;
    delay = 2'($random(seed));
    repeat (3) @(negedge clock);
    slot_pin = 1'b0;
  end
  always @(posedge clock) begin
    if (rd_req && rd_ack) begin
      rd_slot.push_back(slot_no);
      rd_chars.push_back(got_q.size());
    end
    if (c_valid) begin
      got_q.push_back({c_idle, c_data});
      ch_slot.push_back(slot_no);
    end
  end

  // ------------
  // Bench tasks
  // ------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_rd(input int n);
    int k;
    for (k = 0; k < 3000 && rd_slot.size() < n; k++) @(negedge clock);
    if (rd_slot.size() < n) begin
      error_cnt++;
      end_sim();
    end
  endtask
  task automatic cmd(input logic h);
    @(negedge clock);
    cmd_valid = 1'b1;
    hold = h;
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask

  initial begin
    int n;
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    chk(held, 1);
    for (int i = 0; i < 16; i++) begin
      @(negedge clock);
      d_valid = 1'b1;
      d_in = 8'($random(seed));
      exp_q.push_back({1'b0, d_in});
    end
    @(negedge clock);
    chk(d_ready, 0);
    d_valid = 1'b0;
    repeat (40) @(negedge clock);
    chk(rd_slot.size(), 0);
    $display("held start done");
    exp_q.insert(2, 9'h100);
    exp_q.insert(2, 9'h100);
    mem.q.push_back({1'b0, 8'h01, 16'h0002});
    mem.q.push_back({1'b0, 8'h00, 16'h0001});
    repeat (3) mem.q.push_back({1'b1, 8'h00, 16'h000d});
    mem.q.push_back({1'b0, 8'h00, 16'h000d});
    cmd(1'b0);
    wait_rd(4);
    chk(paused, 1);
    wait_rd(10);
    chk(rd_chars[1], 4);
    chk(rd_chars[2], 5);
    chk(rd_chars[6], 18);
    for (int i = 2; i < 5; i++) chk(rd_slot[i+1] - rd_slot[i], 1);
    chk(ch_slot[5] - rd_slot[5], 1);
    chk(rd_slot[8] - rd_slot[7], 4);
    chk(rd_slot[9] - rd_slot[8], 4);
    chk(got_q.size(), 18);
    for (int i = 0; i < 18; i++) chk(got_q[i], exp_q[i]);
    $display("frames done");
    cmd(1'b1);
    chk(held, 1);
    n = rd_slot.size();
    repeat (90) @(negedge clock);
    chk(rd_slot.size(), n);
    cmd(1'b0);
    wait_rd(n + 1);
    chk(held, 0);
    $display("hold done");
    end_sim();
  end
endmodule
